// >>> pkg/irq_ctrl_pkg.sv
// shared constants and types of the nested priority interrupt controller
package irq_ctrl_pkg;
    localparam int NVEC = 30;
    localparam int NEXT = 2;
    localparam int NPIN = 4;
    localparam int NPER = 28;
    localparam int NFLD = 32;
    localparam int APB_AW = 8;

    // two-bit level codes as held in prio_hi_bit:prio_lo_bit
    localparam logic [1:0] LVL0 = 2'h2;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h0;
    localparam logic [1:0] LVL3 = 2'h3;
    localparam logic [1:0] SPR_RST = 2'h3;

    // program memory vectors
    localparam logic [23:0] RESET_VEC = 24'h008000;
    localparam logic [23:0] TRAP_VEC = 24'h008004;
    localparam logic [23:0] VEC_BASE = 24'h008008;

    // maskable vectors able to leave halt (external lines and the first peripheral)
    localparam logic [NVEC-1:0] HALT_WAKE = 30'h00000007;

    // register byte offsets
    localparam logic [APB_AW-1:0] SPR_OFS = 8'h00;
    localparam logic [APB_AW-1:0] SPR_END = 8'h1c;
    localparam logic [APB_AW-1:0] GCFG_OFS = 8'h20;
    localparam logic [APB_AW-1:0] EXTCFG_OFS = 8'h24;
    localparam logic [APB_AW-1:0] STAT_OFS = 8'h28;
    localparam logic [APB_AW-1:0] PEND_OFS = 8'h2c;

    // field positions
    localparam int GCFG_STAY = 0;
    localparam int EXT_SEL_LSB = 0;
    localparam int EXT_LVL_LSB = 8;
    localparam int EXT_EN_LSB = 10;
    localparam int EXTCFG_W = 12;
    localparam logic [EXTCFG_W-1:0] EXTCFG_RST = 12'h000;
    localparam logic GCFG_STAY_RST = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE, OP_MASK_ALL, OP_UNMASK, OP_RETURN,
        OP_WAIT_IRQ, OP_WAIT_EVENT, OP_HALT, OP_TRAP
    } coreOp_t;

    typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_LPWAIT, PWR_HALT} pwrMode_t;

    typedef struct packed {
        logic start;
        logic stack;
        logic [23:0] vector;
    } svc_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } apbReq_t;
endpackage

// >>> rtl/nested_irq_ctrl.sv
// nested priority interrupt controller: arbitration, servicing, low-power wake
// Functional notes
// - service starts only at an instruction boundary or while in wait, low-power wait or halt
// - maskable service entry asks the core to stack the full context
// - entry loads the level bits with the vector's programmed priority
// - reset, trap and maskable vectors sit at fixed four-byte steps
// - return restores the popped level bits and resumes the program
// - level codes: 10 lowest, 01, 00, 11 highest and masking all
// - unmask always sets level 0, even after mask-all inside a routine
// - highest programmed priority wins, ties go to higher hardware priority
// - edge-sensed external requests stay latched until they win or a pending-register write clears them
// - reset and trap rank above every maskable source
// - reset and trap ignore the level; only trap stacks; level becomes 3
// - trap cannot leave halt, reset can; reset starts at level 3
// - maskable vector needs enable and priority above current level
// - selected pins of one external line are ORed together
// - level-sensed external request persists while its level is present
// - peripheral request needs both status flag and its enable
// - peripheral clear sequence drops the latched request
// - wait leaves on any interrupt; low-power wait only on reset or event
// - halt wake services the best wake-capable request first
// - request during halt: halt completes then wakes at once
// - halt is skipped while a peripheral request is pending
// - stay-asleep bit returns to sleep, context saved only once
// - writing level 0 code into a priority field is ignored
module nested_irq_ctrl (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire irq_ctrl_pkg::apbReq_t apbIn,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrEnd,
    input wire irq_ctrl_pkg::coreOp_t instrOp,
    input wire logic [1:0] popLevel,
    input wire logic resetIrq,
    input wire logic eventIn,
    input wire logic [7:0] extPin,
    input wire logic [27:0] periphFlag,
    input wire logic [27:0] periphIrqEn,
    input wire logic [27:0] periphClear,
    output irq_ctrl_pkg::svc_t svc,
    output logic [1:0] curLevel,
    output irq_ctrl_pkg::pwrMode_t pwrMode,
    output logic lpRunMode,
    output logic haltSkip,
    output logic sleepReturn
);
    localparam int NVEC = irq_ctrl_pkg::NVEC;
    localparam int NEXT = irq_ctrl_pkg::NEXT;
    localparam int NPIN = irq_ctrl_pkg::NPIN;

    logic [irq_ctrl_pkg::NFLD-1:0][1:0] spr_reg;
    logic stay_reg;
    logic [irq_ctrl_pkg::EXTCFG_W-1:0] extCfg_reg;
    logic [1:0] level_reg;
    irq_ctrl_pkg::pwrMode_t pwr_reg;
    irq_ctrl_pkg::pwrMode_t sleepKind_reg;
    logic ctxHeld_reg;
    logic lpRun_reg;
    logic rstPend_reg;
    logic [7:0] pinMeta_reg;
    logic [7:0] pinSync_reg;
    logic [NEXT-1:0] linePrev_reg;
    logic [NEXT-1:0] extPend_reg;
    logic [irq_ctrl_pkg::NPER-1:0] perPend_reg;
    logic [31:0] rdata_reg;
    irq_ctrl_pkg::svc_t svc_reg;
    logic haltSkip_reg;
    logic sleepRet_reg;

    function automatic logic [1:0] rank(input logic [1:0] code);
        unique case (code)
            irq_ctrl_pkg::LVL0: rank = 2'h0;
            irq_ctrl_pkg::LVL1: rank = 2'h1;
            irq_ctrl_pkg::LVL2: rank = 2'h2;
            irq_ctrl_pkg::LVL3: rank = 2'h3;
        endcase
    endfunction

    // external lines: synchronise pins, then OR the selected ones
    logic [NEXT-1:0] lineReq;
    logic [NEXT-1:0] lineLevel;
    logic [NEXT-1:0] lineEn;
    always_comb
    begin
        for (int l = 0; l < NEXT; l++)
        begin
            lineReq[l] = |(pinSync_reg[l*NPIN +: NPIN]
                & extCfg_reg[irq_ctrl_pkg::EXT_SEL_LSB + l*NPIN +: NPIN]);
            lineLevel[l] = extCfg_reg[irq_ctrl_pkg::EXT_LVL_LSB + l];
            lineEn[l] = extCfg_reg[irq_ctrl_pkg::EXT_EN_LSB + l];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pinMeta_reg <= 8'h00;
            pinSync_reg <= 8'h00;
            linePrev_reg <= '0;
        end
        else
        begin
            pinMeta_reg <= extPin;
            pinSync_reg <= pinMeta_reg;
            linePrev_reg <= lineReq;
        end
    end

    // arbitration
    logic [NVEC-1:0] pend;
    logic [NVEC-1:0] cand;
    logic found;
    logic [4:0] best;
    logic [1:0] bestRank;
    always_comb
    begin
        pend = {perPend_reg, extPend_reg & lineEn};
        for (int i = 0; i < NVEC; i++)
        begin
            cand[i] = pend[i] && (rank(spr_reg[i]) > rank(level_reg))
                && (pwr_reg != irq_ctrl_pkg::PWR_HALT || irq_ctrl_pkg::HALT_WAKE[i]);
        end
    end

    always_comb
    begin
        found = 1'b0;
        best = 5'h00;
        bestRank = 2'h0;
        // ascending scan with strict compare keeps the lowest index on ties
        for (int i = 0; i < NVEC; i++)
        begin
            if (cand[i] && (!found || rank(spr_reg[i]) > bestRank))
            begin
                found = 1'b1;
                best = 5'(i);
                bestRank = rank(spr_reg[i]);
            end
        end
    end

    logic boundary;
    logic asleep;
    logic fireRst;
    logic fireTrap;
    logic fireMask;
    logic fire;
    logic doStack;
    logic [23:0] vecAddr;
    logic perAny;
    always_comb
    begin
        boundary = instrEnd && pwr_reg == irq_ctrl_pkg::PWR_RUN;
        asleep = pwr_reg == irq_ctrl_pkg::PWR_WAIT || pwr_reg == irq_ctrl_pkg::PWR_HALT;
        perAny = |perPend_reg;
        fireRst = rstPend_reg && (boundary || pwr_reg != irq_ctrl_pkg::PWR_RUN);
        fireTrap = !fireRst && boundary && instrOp == irq_ctrl_pkg::OP_TRAP;
        fireMask = !rstPend_reg && !fireTrap && found && (boundary || asleep);
        fire = fireRst || fireTrap || fireMask;
        doStack = fireTrap || (fireMask && !(ctxHeld_reg && asleep));
        if (fireRst)
            vecAddr = irq_ctrl_pkg::RESET_VEC;
        else if (fireTrap)
            vecAddr = irq_ctrl_pkg::TRAP_VEC;
        else
            vecAddr = irq_ctrl_pkg::VEC_BASE + {17'h00000, best, 2'h0};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            svc_reg <= '0;
        else
        begin
            svc_reg.start <= fire;
            svc_reg.stack <= fire && doStack;
            svc_reg.vector <= fire ? vecAddr : svc_reg.vector;
        end
    end

    // reset source stays latched until its vector is taken
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            rstPend_reg <= 1'b0;
        else if (resetIrq)
            rstPend_reg <= 1'b1;
        else if (fireRst)
            rstPend_reg <= 1'b0;
    end

    // request latches
    logic [31:0] pendW1c;
    logic apbWrite;
    always_comb
    begin
        apbWrite = apbIn.psel && apbIn.penable && apbIn.pwrite;
        pendW1c = (apbWrite && apbIn.paddr == irq_ctrl_pkg::PEND_OFS) ? apbIn.pwdata : 32'h0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            extPend_reg <= '0;
        else
        begin
            for (int l = 0; l < NEXT; l++)
            begin
                if (lineLevel[l])
                    extPend_reg[l] <= lineReq[l];
                else if (lineReq[l] && !linePrev_reg[l])
                    extPend_reg[l] <= 1'b1;
                else if ((fireMask && best == 5'(l)) || pendW1c[l])
                    extPend_reg[l] <= 1'b0;
            end
        end
    end

    // the clear drops what was pending; a flag raised in that same cycle still wins
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            perPend_reg <= '0;
        else
            perPend_reg <= (perPend_reg & ~periphClear) | (periphFlag & periphIrqEn);
    end

    // current level bits
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            level_reg <= irq_ctrl_pkg::LVL3;
        else if (fireRst || fireTrap)
            level_reg <= irq_ctrl_pkg::LVL3;
        else if (fireMask)
            level_reg <= spr_reg[best];
        else if (boundary)
        begin
            unique case (instrOp)
                irq_ctrl_pkg::OP_MASK_ALL: level_reg <= irq_ctrl_pkg::LVL3;
                irq_ctrl_pkg::OP_UNMASK: level_reg <= irq_ctrl_pkg::LVL0;
                irq_ctrl_pkg::OP_RETURN:
                    level_reg <= (stay_reg && ctxHeld_reg) ? irq_ctrl_pkg::LVL0 : popLevel;
                irq_ctrl_pkg::OP_WAIT_IRQ,
                irq_ctrl_pkg::OP_WAIT_EVENT,
                irq_ctrl_pkg::OP_HALT: level_reg <= irq_ctrl_pkg::LVL0;
                irq_ctrl_pkg::OP_NONE,
                irq_ctrl_pkg::OP_TRAP: level_reg <= level_reg;
            endcase
        end
    end

    // power mode sequencing
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pwr_reg <= irq_ctrl_pkg::PWR_RUN;
            sleepKind_reg <= irq_ctrl_pkg::PWR_WAIT;
            haltSkip_reg <= 1'b0;
            sleepRet_reg <= 1'b0;
        end
        else
        begin
            haltSkip_reg <= 1'b0;
            sleepRet_reg <= 1'b0;
            if (fire)
                pwr_reg <= irq_ctrl_pkg::PWR_RUN;
            else
            begin
                unique case (pwr_reg)
                    irq_ctrl_pkg::PWR_RUN:
                    begin
                        if (boundary && instrOp == irq_ctrl_pkg::OP_WAIT_IRQ)
                        begin
                            pwr_reg <= irq_ctrl_pkg::PWR_WAIT;
                            sleepKind_reg <= irq_ctrl_pkg::PWR_WAIT;
                        end
                        else if (boundary && instrOp == irq_ctrl_pkg::OP_WAIT_EVENT)
                            pwr_reg <= irq_ctrl_pkg::PWR_LPWAIT;
                        else if (boundary && instrOp == irq_ctrl_pkg::OP_HALT)
                        begin
                            if (perAny)
                                haltSkip_reg <= 1'b1;
                            else
                            begin
                                pwr_reg <= irq_ctrl_pkg::PWR_HALT;
                                sleepKind_reg <= irq_ctrl_pkg::PWR_HALT;
                            end
                        end
                        else if (boundary && instrOp == irq_ctrl_pkg::OP_RETURN
                            && stay_reg && ctxHeld_reg)
                        begin
                            pwr_reg <= sleepKind_reg;
                            sleepRet_reg <= 1'b1;
                        end
                    end
                    irq_ctrl_pkg::PWR_LPWAIT:
                        if (eventIn)
                            pwr_reg <= irq_ctrl_pkg::PWR_RUN;
                    irq_ctrl_pkg::PWR_WAIT,
                    irq_ctrl_pkg::PWR_HALT: pwr_reg <= pwr_reg;
                endcase
            end
        end
    end

    // event wake from low-power wait lands in low-power run
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            lpRun_reg <= 1'b0;
        else if (fireRst)
            lpRun_reg <= 1'b0;
        else if (pwr_reg == irq_ctrl_pkg::PWR_LPWAIT && eventIn)
            lpRun_reg <= 1'b1;
    end

    // nested returns while the context is held also go back to sleep;
    // software clears the stay bit in the outermost routine to resume main
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            ctxHeld_reg <= 1'b0;
        else if (fireRst)
            ctxHeld_reg <= 1'b0;
        else if (fireMask && asleep && stay_reg)
            ctxHeld_reg <= 1'b1;
        else if (boundary && instrOp == irq_ctrl_pkg::OP_RETURN && !stay_reg)
            ctxHeld_reg <= 1'b0;
    end

    // register bus
    logic mapped;
    logic [31:0] rdMux;
    logic [4:0] fldBase;
    always_comb
    begin
        mapped = apbIn.paddr[1:0] == 2'h0 && apbIn.paddr <= irq_ctrl_pkg::PEND_OFS;
        fldBase = {apbIn.paddr[4:2], 2'h0};
        rdMux = 32'h0;
        if (apbIn.paddr <= irq_ctrl_pkg::SPR_END)
            rdMux = {24'h000000, spr_reg[fldBase +: 4]};
        else if (apbIn.paddr == irq_ctrl_pkg::GCFG_OFS)
            rdMux = {31'h0, stay_reg};
        else if (apbIn.paddr == irq_ctrl_pkg::EXTCFG_OFS)
            rdMux = {20'h00000, extCfg_reg};
        else if (apbIn.paddr == irq_ctrl_pkg::STAT_OFS)
            rdMux = {26'h0, ctxHeld_reg, lpRun_reg, 2'(pwr_reg), level_reg};
        else if (apbIn.paddr == irq_ctrl_pkg::PEND_OFS)
            rdMux = {2'h0, pend};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            rdata_reg <= 32'h0;
        else if (apbIn.psel && !apbIn.penable)
            rdata_reg <= rdMux;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            spr_reg <= {irq_ctrl_pkg::NFLD{irq_ctrl_pkg::SPR_RST}};
            stay_reg <= irq_ctrl_pkg::GCFG_STAY_RST;
            extCfg_reg <= irq_ctrl_pkg::EXTCFG_RST;
        end
        else if (apbWrite)
        begin
            for (int j = 0; j < irq_ctrl_pkg::NFLD; j++)
            begin
                if (apbIn.paddr <= irq_ctrl_pkg::SPR_END && 3'(j / 4) == apbIn.paddr[4:2]
                    && apbIn.pwdata[2*(j%4) +: 2] != irq_ctrl_pkg::LVL0)
                    spr_reg[j] <= apbIn.pwdata[2*(j%4) +: 2];
            end
            if (apbIn.paddr == irq_ctrl_pkg::GCFG_OFS)
                stay_reg <= apbIn.pwdata[irq_ctrl_pkg::GCFG_STAY];
            if (apbIn.paddr == irq_ctrl_pkg::EXTCFG_OFS)
                extCfg_reg <= apbIn.pwdata[irq_ctrl_pkg::EXTCFG_W-1:0];
        end
    end

    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = apbIn.psel && apbIn.penable && !mapped;
    assign svc = svc_reg;
    assign curLevel = level_reg;
    assign pwrMode = pwr_reg;
    assign lpRunMode = lpRun_reg;
    assign haltSkip = haltSkip_reg;
    assign sleepReturn = sleepRet_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    svc_boundary_a: assert property (svc.start |-> $past(instrEnd)
        || $past(pwr_reg) != irq_ctrl_pkg::PWR_RUN)
        else $error("service started mid instruction");
    trap_stack_a: assert property (fireTrap |=> svc.start && svc.stack
        && svc.vector == irq_ctrl_pkg::TRAP_VEC && level_reg == irq_ctrl_pkg::LVL3)
        else $error("trap entry wrong");
    reset_nostack_a: assert property (fireRst |=> svc.start && !svc.stack
        && svc.vector == irq_ctrl_pkg::RESET_VEC && level_reg == irq_ctrl_pkg::LVL3)
        else $error("reset entry wrong");
    mask_level_a: assert property (fireMask |=> level_reg == $past(spr_reg[best])
        && svc.vector == irq_ctrl_pkg::VEC_BASE + {17'h00000, $past(best), 2'h0})
        else $error("maskable entry level or vector wrong");
    unmask_level_a: assert property (boundary && !fire
        && instrOp == irq_ctrl_pkg::OP_UNMASK |=> curLevel == irq_ctrl_pkg::LVL0)
        else $error("unmask did not set level 0");
    spr_no_lvl0_a: assert property (!(|(spr_reg & ~(spr_reg << 1)
        & 64'haaaaaaaaaaaaaaaa)))
        else $error("level 0 code stored in priority field");
    halt_skip_a: assert property (boundary && !fire && perAny
        && instrOp == irq_ctrl_pkg::OP_HALT |=> haltSkip ##1 pwrMode == irq_ctrl_pkg::PWR_RUN)
        else $error("halt not skipped with pending peripheral");
    lpwait_hold_a: assert property (pwrMode == irq_ctrl_pkg::PWR_LPWAIT
        && !eventIn && !rstPend_reg && !resetIrq |=> pwrMode == irq_ctrl_pkg::PWR_LPWAIT)
        else $error("low-power wait left without reset or event");
    return_level_a: assert property (boundary && !fire && !(stay_reg && ctxHeld_reg)
        && instrOp == irq_ctrl_pkg::OP_RETURN |=> curLevel == $past(popLevel))
        else $error("return did not restore level");
    lower_rank_a: assert property (fireMask |-> rank(spr_reg[best]) > rank(level_reg))
        else $error("serviced vector not above level");
endmodule

// >>> test/core_model.sv
// behavioural core: ends instructions on command and keeps the saved level stack
module core_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmdGo,
    input wire irq_ctrl_pkg::coreOp_t cmdOp,
    input wire irq_ctrl_pkg::svc_t svc,
    input wire logic [1:0] curLevel,
    output logic instrEnd = 1'b0,
    output irq_ctrl_pkg::coreOp_t instrOp = irq_ctrl_pkg::OP_NONE,
    output logic [1:0] popLevel = 2'h2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] stk [8];
    logic [2:0] sp = 3'h0;
    logic [2:0] top;
    logic [1:0] lvlPrev = 2'h3;
    // a return that went back to sleep leaves the first context in place
    assign top = (sp == 3'h0) ? 3'h0 : sp - 3'h1;
    // op and popped level mean nothing between instruction ends, so they are scrambled
    always_ff @(posedge ref_clk)
    begin
        lvlPrev <= curLevel;
        instrEnd <= resetn & cmdGo;
        instrOp <= cmdGo ? cmdOp : irq_ctrl_pkg::coreOp_t'(~instrOp);
        popLevel <= cmdGo ? stk[top] : ~popLevel;
        if (!resetn)
            sp <= 3'h0;
        else if (svc.start && svc.stack)
        begin
            stk[sp] <= lvlPrev;
            sp <= sp + 3'h1;
        end
        else if (cmdGo && cmdOp == irq_ctrl_pkg::OP_RETURN)
            sp <= top;
    end
endmodule

// >>> test/tb_nested_priority_interrupt_ctrl.sv
// self-checking bench of the nested priority interrupt controller
module tb_nested_priority_interrupt_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] spr;
        logic [1:0] en;
        logic [23:0] vec;
        logic [1:0] lvl;
    } row_t;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    irq_ctrl_pkg::apbReq_t apbIn = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, instrEnd, err, lpRunMode, haltSkip, sleepReturn;
    logic resetIrq = 1'b0, eventIn = 1'b0, cmdGo = 1'b0;
    logic [7:0] extPin = 8'h00;
    irq_ctrl_pkg::coreOp_t instrOp;
    irq_ctrl_pkg::coreOp_t cmdOp = irq_ctrl_pkg::OP_NONE;
    logic [1:0] popLevel, curLevel;
    logic [27:0] periphFlag = '0, periphIrqEn = '0, periphClear = '0;
    irq_ctrl_pkg::svc_t svc;
    irq_ctrl_pkg::pwrMode_t pwrMode;
    int nFail = 0, checkCount = 0;
    // byte 0 of the first priority word sets vectors 0..3; peripheral k is vector k+2
    row_t rows [5] = '{
        '{8'h1f, 2'h3, 24'h008014, irq_ctrl_pkg::LVL2},
        '{8'h0f, 2'h3, 24'h008010, irq_ctrl_pkg::LVL2},
        '{8'h7f, 2'h3, 24'h008010, irq_ctrl_pkg::LVL3},
        '{8'h5f, 2'h3, 24'h008010, irq_ctrl_pkg::LVL1},
        '{8'h7f, 2'h2, 24'h008014, irq_ctrl_pkg::LVL1}};

    always #2.5 ref_clk = ~ref_clk;

    nested_irq_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .apbIn(apbIn),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instrEnd(instrEnd),
        .instrOp(instrOp), .popLevel(popLevel), .resetIrq(resetIrq), .eventIn(eventIn),
        .extPin(extPin), .periphFlag(periphFlag), .periphIrqEn(periphIrqEn),
        .periphClear(periphClear), .svc(svc), .curLevel(curLevel), .pwrMode(pwrMode),
        .lpRunMode(lpRunMode), .haltSkip(haltSkip), .sleepReturn(sleepReturn));

    core_model i_core (.ref_clk(ref_clk), .resetn(resetn), .cmdGo(cmdGo), .cmdOp(cmdOp),
        .svc(svc), .curLevel(curLevel), .instrEnd(instrEnd), .instrOp(instrOp),
        .popLevel(popLevel));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checkCount++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        apbIn <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk);
        apbIn.penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbIn <= '0;
    endtask

    // returns once the decision edge has landed, so level and mode are settled
    task automatic op(input irq_ctrl_pkg::coreOp_t o);
        @(posedge ref_clk);
        cmdOp <= o;
        cmdGo <= 1'b1;
        @(posedge ref_clk);
        cmdGo <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic clr();
        periphFlag <= '0;
        periphClear <= '1;
        @(posedge ref_clk);
        periphClear <= '0;
    endtask

    task automatic chkSvc(input logic [23:0] v, input logic [1:0] l, input logic s);
        int i = 0;
        while (svc.start !== 1'b1 && i < 40)
        begin
            @(posedge ref_clk);
            i++;
        end
        chk(svc.start, 1'b1, "service start");
        chk(svc.vector, v, "vector");
        chk(curLevel, l, "entry level");
        chk(svc.stack, s, "stacking");
    endtask

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        nFail++;
        finishTest();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk(curLevel, irq_ctrl_pkg::LVL3, "reset level");
        chk(pwrMode, irq_ctrl_pkg::PWR_RUN, "reset mode");
        chk({svc.start, lpRunMode}, 32'h0, "reset pulses");
        apb(1'b0, irq_ctrl_pkg::SPR_OFS, 32'h0);
        chk(rd, 32'h000000ff, "priority reset");
        apb(1'b1, irq_ctrl_pkg::SPR_OFS, 32'hffffff64);
        apb(1'b0, irq_ctrl_pkg::SPR_OFS, 32'h0);
        chk(rd, 32'h00000074, "level 0 write");
        apb(1'b0, 8'h40, 32'h0);
        chk({err, pready}, 2'h3, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("reset test done");
        foreach (rows[i])
        begin
            apb(1'b1, irq_ctrl_pkg::SPR_OFS, {24'hffffff, rows[i].spr});
            op(irq_ctrl_pkg::OP_UNMASK);
            chk(curLevel, irq_ctrl_pkg::LVL0, "unmask level");
            periphIrqEn <= {26'h0, rows[i].en};
            periphFlag <= 28'h3;
            op(irq_ctrl_pkg::OP_NONE);
            chkSvc(rows[i].vec, rows[i].lvl, 1'b1);
            clr();
            op(irq_ctrl_pkg::OP_RETURN);
            chk(curLevel, irq_ctrl_pkg::LVL0, "return level");
        end
        $display("arbitration test done");
        op(irq_ctrl_pkg::OP_TRAP);
        chkSvc(irq_ctrl_pkg::TRAP_VEC, irq_ctrl_pkg::LVL3, 1'b1);
        op(irq_ctrl_pkg::OP_MASK_ALL);
        op(irq_ctrl_pkg::OP_UNMASK);
        chk(curLevel, irq_ctrl_pkg::LVL0, "unmask after mask all");
        op(irq_ctrl_pkg::OP_RETURN);
        op(irq_ctrl_pkg::OP_MASK_ALL);
        periphIrqEn <= 28'h3;
        periphFlag <= 28'h1;
        op(irq_ctrl_pkg::OP_HALT);
        chk(haltSkip, 1'b1, "halt refused");
        chk(pwrMode, irq_ctrl_pkg::PWR_RUN, "halt refused mode");
        clr();
        apb(1'b1, irq_ctrl_pkg::SPR_OFS, 32'hffffff1f);
        op(irq_ctrl_pkg::OP_HALT);
        chk(pwrMode, irq_ctrl_pkg::PWR_HALT, "halt entered");
        periphFlag <= 28'h3;
        chkSvc(24'h008010, irq_ctrl_pkg::LVL1, 1'b1);
        chk(pwrMode, irq_ctrl_pkg::PWR_RUN, "halt wake");
        op(irq_ctrl_pkg::OP_NONE);
        chkSvc(24'h008014, irq_ctrl_pkg::LVL2, 1'b1);
        clr();
        op(irq_ctrl_pkg::OP_RETURN);
        op(irq_ctrl_pkg::OP_RETURN);
        chk(curLevel, irq_ctrl_pkg::LVL0, "nested returns");
        $display("trap and halt test done");
        op(irq_ctrl_pkg::OP_WAIT_IRQ);
        chk(pwrMode, irq_ctrl_pkg::PWR_WAIT, "wait entered");
        periphFlag <= 28'h2;
        chkSvc(24'h008014, irq_ctrl_pkg::LVL2, 1'b1);
        clr();
        op(irq_ctrl_pkg::OP_RETURN);
        apb(1'b1, irq_ctrl_pkg::GCFG_OFS, 32'h1);
        op(irq_ctrl_pkg::OP_WAIT_IRQ);
        periphFlag <= 28'h2;
        chkSvc(24'h008014, irq_ctrl_pkg::LVL2, 1'b1);
        clr();
        op(irq_ctrl_pkg::OP_RETURN);
        chk(sleepReturn, 1'b1, "back to sleep");
        chk(pwrMode, irq_ctrl_pkg::PWR_WAIT, "sleep mode");
        periphFlag <= 28'h2;
        chkSvc(24'h008014, irq_ctrl_pkg::LVL2, 1'b0);
        apb(1'b1, irq_ctrl_pkg::GCFG_OFS, 32'h0);
        clr();
        op(irq_ctrl_pkg::OP_RETURN);
        chk(pwrMode, irq_ctrl_pkg::PWR_RUN, "main resumed");
        $display("wait test done");
        op(irq_ctrl_pkg::OP_WAIT_EVENT);
        chk(pwrMode, irq_ctrl_pkg::PWR_LPWAIT, "low-power wait");
        periphFlag <= 28'h2;
        repeat (6) @(posedge ref_clk);
        chk(pwrMode, irq_ctrl_pkg::PWR_LPWAIT, "irq ignored");
        clr();
        eventIn <= 1'b1;
        @(posedge ref_clk);
        eventIn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(pwrMode, irq_ctrl_pkg::PWR_RUN, "event wake");
        chk(lpRunMode, 1'b1, "low-power run");
        resetIrq <= 1'b1;
        periphFlag <= 28'h2;
        @(posedge ref_clk);
        resetIrq <= 1'b0;
        op(irq_ctrl_pkg::OP_NONE);
        chkSvc(irq_ctrl_pkg::RESET_VEC, irq_ctrl_pkg::LVL3, 1'b0);
        clr();
        repeat (2) @(posedge ref_clk);
        chk(lpRunMode, 1'b0, "reset leaves low-power run");
        $display("low-power test done");
        apb(1'b1, irq_ctrl_pkg::EXTCFG_OFS, 32'h00000506);
        op(irq_ctrl_pkg::OP_UNMASK);
        extPin <= 8'h04;
        repeat (4) @(posedge ref_clk);
        op(irq_ctrl_pkg::OP_NONE);
        chkSvc(irq_ctrl_pkg::VEC_BASE, irq_ctrl_pkg::LVL3, 1'b1);
        extPin <= 8'h02;
        op(irq_ctrl_pkg::OP_RETURN);
        apb(1'b0, irq_ctrl_pkg::PEND_OFS, 32'h0);
        chk(rd, 32'h00000001, "level request kept");
        op(irq_ctrl_pkg::OP_NONE);
        chkSvc(irq_ctrl_pkg::VEC_BASE, irq_ctrl_pkg::LVL3, 1'b1);
        extPin <= 8'h00;
        op(irq_ctrl_pkg::OP_RETURN);
        apb(1'b0, irq_ctrl_pkg::PEND_OFS, 32'h0);
        chk(rd, 32'h00000000, "level request dropped");
        $display("external test done");
        finishTest();
    end
endmodule
